// File: common/bgss_pkg.sv
package bgss_pkg;

  // ----------------------------------------------------------------
  // Clock and time conversion
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;

  // A least time rounds up to whole cycles, never below one.
  function automatic int ns_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // A longest time rounds down to whole cycles, never below one.
  function automatic int ns_dn(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ----------------------------------------------------------------
  // Times in their own unit
  // ----------------------------------------------------------------
  localparam int SW_PERIOD_NS = 500;
  localparam int BOOT_PULSE_NS = 250;
  localparam int BOOT_PERIOD_NS = 2000;
  localparam int HS_LONG_ON_NS = 16000;
  localparam int HS_LONG_OFF_NS = 200;
  localparam int SW_WATCH_NS = 70;
  localparam int LS_FORCE_NS = 100;
  localparam int STOP_DELAY_NS = 15000;
  localparam int OV_RESPONSE_NS = 2700;
  localparam int EN_FILTER_NS = 1000;
  localparam int RESET_FILTER_NS = 1000;
  localparam int SSDLY_NS = 100000;

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam logic [11:0] SW_PERIOD_CYC = 12'(ns_dn(SW_PERIOD_NS));
  localparam logic [11:0] BOOT_PULSE_CYC = 12'(ns_up(BOOT_PULSE_NS));
  localparam logic [11:0] BOOT_PERIOD_CYC = 12'(ns_dn(BOOT_PERIOD_NS));
  localparam logic [11:0] HS_LONG_ON_CYC = 12'(ns_dn(HS_LONG_ON_NS));
  localparam logic [11:0] HS_LONG_OFF_CYC = 12'(ns_up(HS_LONG_OFF_NS));
  localparam logic [11:0] SW_WATCH_CYC = 12'(ns_dn(SW_WATCH_NS));
  localparam logic [11:0] LS_FORCE_CYC = 12'(ns_up(LS_FORCE_NS));
  localparam logic [11:0] STOP_DELAY_CYC = 12'(ns_up(STOP_DELAY_NS));
  localparam logic [11:0] OV_RESPONSE_CYC = 12'(ns_dn(OV_RESPONSE_NS));
  localparam logic [11:0] EN_FILTER_CYC = 12'(ns_up(EN_FILTER_NS));
  localparam logic [11:0] RESET_FILTER_CYC = 12'(ns_up(RESET_FILTER_NS));
  localparam logic [11:0] SSDLY_CYC = 12'(ns_up(SSDLY_NS));

  localparam logic [3:0] BOOT_PULSES = 4'h8;
  localparam logic [1:0] BURST_PULSES = 2'h3;
  localparam logic [1:0] BURST_DIV_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Reset release: delay_cycles * current_ua >= product
  // ----------------------------------------------------------------
  localparam longint RESET_COEF_TENTH_MS = 99;
  localparam longint RESET_PRODUCT_L =
    RESET_COEF_TENTH_MS * 64'd100000 * 64'd1000 / (64'd4 * CLK_PERIOD_NS);
  localparam logic [25:0] RESET_PRODUCT = 26'(RESET_PRODUCT_L);
  localparam logic [10:0] NO_DELAY_UA = 11'h3e8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    BGSS_OFF = 5'h01,
    BGSS_SSDLY = 5'h02,
    BGSS_BOOT = 5'h04,
    BGSS_RUN = 5'h08,
    BGSS_STOP = 5'h10
  } bgss_state_type;

  typedef enum logic [1:0] {
    BGSS_CLAMP_NONE = 2'h0,
    BGSS_CLAMP_PSKIP = 2'h1,
    BGSS_CLAMP_BURST = 2'h2,
    BGSS_CLAMP_NORMAL = 2'h3
  } bgss_clamp_type;

endpackage

// File: core/bgss_filter.sv
`timescale 1ns/1ps
`default_nettype none
module bgss_filter #(
  parameter logic [11:0] CYCLES = 12'h00a
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic raw,
  output logic filtered
);

  typedef struct packed {
    logic level;
    logic [11:0] cnt;
  } bgss_filter_state_type;

  bgss_filter_state_type r;
  bgss_filter_state_type next_r;

  // A change must persist for CYCLES clocks before it is taken.
  always_comb begin
    next_r = r;
    if (raw == r.level) begin
      next_r.cnt = 12'h000;
    end else if (r.cnt >= CYCLES - 12'h001) begin
      next_r.level = raw;
      next_r.cnt = 12'h000;
    end else begin
      next_r.cnt = r.cnt + 12'h001;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign filtered = r.level;

endmodule
`default_nettype wire

// File: core/bgss_release.sv
`timescale 1ns/1ps
`default_nettype none
module bgss_release #(
  parameter logic [25:0] PRODUCT = bgss_pkg::RESET_PRODUCT
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic fault,
  input wire logic [10:0] pullup_current_ua,
  output logic pull_low
);

  typedef struct packed {
    logic pull;
    logic [25:0] acc;
  } bgss_release_state_type;

  bgss_release_state_type r;
  bgss_release_state_type next_r;

  // Accumulating the current each cycle avoids a divider: the delay ends
  // once cycles times current reaches the fixed product.
  always_comb begin
    next_r = r;
    if (fault) begin
      next_r.pull = 1'b1;
      next_r.acc = 26'h0000000;
    end else if (r.pull) begin
      if (pullup_current_ua >= bgss_pkg::NO_DELAY_UA) begin
        next_r.pull = 1'b0;
      end else begin
        next_r.acc = r.acc + {15'h0000, pullup_current_ua};
        if (next_r.acc >= PRODUCT) begin
          next_r.pull = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r <= '{pull: 1'b1, acc: 26'h0000000};
    end else begin
      r <= next_r;
    end
  end

  assign pull_low = r.pull;

endmodule
`default_nettype wire

// File: core/bgss_top.sv
// Behaviour
// - Current limit ends the high-side pulse early, folding the output back.
// - Current over limit at cycle start skips high-side pulse; low-side continues.
// - Reset output stays undriven while the sequencer is off (BGSS_OFF).
// - Output under or over voltage pulls reset low after a filter delay.
// - Below 1 mA pull-up, release delay is 9.9 over four times current.
// - A 1 mA pull-up gives no release delay, acting as power good.
// - Overvoltage enables the 1 mA discharge path within 2.7 us.
// - Low enable means shutdown: regulator stopped, functions disabled.
// - In shutdown, output pull-down connects while input exceeds 4.5 V.
// - Every enable starts a fresh soft-start sequence.
// - Enable input is filtered so short noise pulses change nothing.
// - A fixed delay follows enable before soft-start activity begins.
// - After enable falls, switching continues about 15 us, then stops.
// - Low-quiescent mode only in diode emulation; output monitor still triggers bursts.
// - At maximum duty with low input, high-side off pulses are skipped.
// - Low input and low output: 16 us high-side on, 200 ns off.
// - Switch node low within 70 ns sets low-side; otherwise 100 ns forced pulse.
// - At light load the logic enters pulse-skip mode.
// - Clamp: none at startup, 0.975 V pulse-skip, 1.075 V in burst.
// - Eight 250 ns low-side pulses, 2 us period, precede the soft-start ramp.
// - No high-side pulses during the bootstrap charging sequence.
// - Bootstrap pulses may be omitted when output is below about 0.2 V.
`timescale 1ns/1ps
`default_nettype none
module bgss_top #(
  parameter logic [25:0] RESET_PRODUCT = bgss_pkg::RESET_PRODUCT
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic enable_in,
  input wire logic current_limit,
  input wire logic pwm_trip,
  input wire logic zero_current,
  input wire logic switch_node_sense,
  input wire logic undervoltage_threshold,
  input wire logic overvoltage_threshold,
  input wire logic low_input_threshold,
  input wire logic output_below_regulation,
  input wire logic vin_above_4v5,
  input wire logic vout_below_0v2,
  input wire logic light_load,
  input wire logic softstart_done,
  input wire logic [10:0] pullup_current_ua,
  input wire logic reset_out_open_drain_in,
  output logic reset_out_open_drain_out,
  output logic reset_out_open_drain_oe_n,
  output logic high_side_gate,
  output logic low_side_gate,
  output logic softstart_enable,
  output logic discharge_1ma_en,
  output logic shutdown_pulldown_en,
  output logic low_iq_mode,
  output logic [1:0] error_amplifier_clamp,
  output logic pin_low_seen
);

  typedef struct packed {
    bgss_pkg::bgss_state_type state;
    logic [11:0] tmr;
    logic [3:0] boot_cnt;
    logic [11:0] phase;
    logic hs;
    logic ls;
    logic ls_hold;
    logic [11:0] hs_cnt;
    logic [11:0] off_cnt;
    logic [11:0] watch;
    logic [11:0] force_cnt;
    logic pskip;
    logic [1:0] burst_cnt;
    logic [1:0] burst_div;
    logic ov;
    logic pin_low;
  } bgss_top_state_type;

  bgss_top_state_type r;
  bgss_top_state_type next_r;
  logic en_f;
  logic fault_f;
  logic pull_low;
  logic switching;
  logic long_mode;
  logic tick;
  logic fire;
  logic hs_end;

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  // enable noise filter
  bgss_filter #(.CYCLES(bgss_pkg::EN_FILTER_CYC)) u_en_filter (
    .mclk(mclk),
    .nrst(nrst),
    .raw(enable_in),
    .filtered(en_f)
  );

  bgss_filter #(.CYCLES(bgss_pkg::RESET_FILTER_CYC)) u_fault_filter (
    .mclk(mclk),
    .nrst(nrst),
    .raw(undervoltage_threshold | overvoltage_threshold),
    .filtered(fault_f)
  );

  bgss_release #(.PRODUCT(RESET_PRODUCT)) u_release (
    .mclk(mclk),
    .nrst(nrst),
    .fault(fault_f),
    .pullup_current_ua(pullup_current_ua),
    .pull_low(pull_low)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    switching = (r.state == bgss_pkg::BGSS_RUN) || (r.state == bgss_pkg::BGSS_STOP);
    long_mode = low_input_threshold && output_below_regulation;
    tick = (r.phase == bgss_pkg::SW_PERIOD_CYC - 12'h001);
    fire = 1'b0;
    hs_end = 1'b0;
    next_r.ov = overvoltage_threshold;
    next_r.pin_low = !reset_out_open_drain_in;
    next_r.tmr = r.tmr + 12'h001;
    next_r.phase = tick ? 12'h000 : r.phase + 12'h001;
    next_r.pskip = light_load && switching;
    if (r.pskip && !next_r.pskip) begin
      next_r.burst_cnt = bgss_pkg::BURST_PULSES;
      next_r.burst_div = 2'h0;
    end
    case (r.state)
      bgss_pkg::BGSS_OFF: begin
        next_r.hs = 1'b0;
        next_r.ls = 1'b0;
        if (en_f) begin
          next_r.state = bgss_pkg::BGSS_SSDLY;
          next_r.tmr = 12'h000;
        end
      end
      bgss_pkg::BGSS_SSDLY: begin
        if (!en_f) begin
          next_r.state = bgss_pkg::BGSS_OFF;
        end else if (r.tmr == bgss_pkg::SSDLY_CYC - 12'h001) begin
          next_r.tmr = 12'h000;
          next_r.boot_cnt = 4'h0;
          next_r.state = vout_below_0v2 ? bgss_pkg::BGSS_RUN : bgss_pkg::BGSS_BOOT;
        end
      end
      bgss_pkg::BGSS_BOOT: begin
        next_r.hs = 1'b0;
        next_r.ls = en_f && (r.tmr < bgss_pkg::BOOT_PULSE_CYC);
        if (r.tmr == bgss_pkg::BOOT_PERIOD_CYC - 12'h001) begin
          next_r.tmr = 12'h000;
          next_r.boot_cnt = r.boot_cnt + 4'h1;
          if (r.boot_cnt == bgss_pkg::BOOT_PULSES - 4'h1) begin
            next_r.state = bgss_pkg::BGSS_RUN;
            next_r.ls = 1'b0;
          end
        end
        if (!en_f) begin
          next_r.state = bgss_pkg::BGSS_OFF;
        end
      end
      bgss_pkg::BGSS_RUN: begin
        if (!en_f) begin
          next_r.state = bgss_pkg::BGSS_STOP;
          next_r.tmr = 12'h000;
        end
      end
      bgss_pkg::BGSS_STOP: begin
        if (en_f) begin
          next_r.state = bgss_pkg::BGSS_SSDLY;
          next_r.tmr = 12'h000;
          next_r.hs = 1'b0;
          next_r.ls = 1'b0;
        end else if (r.tmr == bgss_pkg::STOP_DELAY_CYC - 12'h001) begin
          next_r.state = bgss_pkg::BGSS_OFF;
        end
      end
      default: begin
        next_r.state = bgss_pkg::BGSS_OFF;
      end
    endcase

    // ----------------------------------------------------------------
    // Gate pulses while switching
    // ----------------------------------------------------------------
    if (switching && next_r.state != bgss_pkg::BGSS_OFF
        && next_r.state != bgss_pkg::BGSS_SSDLY) begin
      if (r.off_cnt != 12'h000) begin
        next_r.off_cnt = r.off_cnt - 12'h001;
      end
      if (r.hs) begin
        next_r.hs_cnt = r.hs_cnt + 12'h001;
        if (current_limit) begin
          hs_end = 1'b1;
        end
        if (pwm_trip && !long_mode) begin
          hs_end = 1'b1;
        end
        // off pulse kept only above low input
        if (tick && !low_input_threshold) begin
          hs_end = 1'b1;
        end
        if (r.hs_cnt == bgss_pkg::HS_LONG_ON_CYC - 12'h001) begin
          hs_end = 1'b1;
          next_r.off_cnt = bgss_pkg::HS_LONG_OFF_CYC - 12'h001;
        end
        if (hs_end) begin
          next_r.hs = 1'b0;
          next_r.watch = bgss_pkg::SW_WATCH_CYC;
        end
      end else begin
        if (r.watch != 12'h000) begin
          next_r.watch = r.watch - 12'h001;
          if (switch_node_sense) begin
            next_r.ls_hold = 1'b1;
            next_r.ls = 1'b1;
            next_r.watch = 12'h000;
          end else if (r.watch == 12'h001) begin
            next_r.force_cnt = bgss_pkg::LS_FORCE_CYC;
            next_r.ls = 1'b1;
          end
        end
        if (r.force_cnt != 12'h000) begin
          next_r.force_cnt = r.force_cnt - 12'h001;
          if (r.force_cnt == 12'h001 && !r.ls_hold) begin
            next_r.ls = 1'b0;
          end
        end
        // Diode emulation: low side released at zero inductor current.
        if (r.ls_hold && zero_current) begin
          next_r.ls_hold = 1'b0;
          next_r.ls = 1'b0;
        end
        // Burst after pulse skip runs at a quarter of the switching rate.
        if (tick && r.burst_cnt != 2'h0) begin
          next_r.burst_div = r.burst_div + 2'h1;
        end
        if (r.watch == 12'h000 && r.force_cnt <= 12'h001) begin
          fire = long_mode ? (r.off_cnt == 12'h000) : tick;
          if (r.burst_cnt != 2'h0 && r.burst_div != 2'h0) begin
            fire = 1'b0;
          end
          if (r.pskip && !output_below_regulation) begin
            fire = 1'b0;
          end
          // skip high side, keep low side
          if (fire && current_limit) begin
            fire = 1'b0;
            next_r.ls = 1'b1;
            next_r.ls_hold = 1'b1;
          end
        end
        if (fire) begin
          next_r.ls = 1'b0;
          next_r.ls_hold = 1'b0;
          next_r.hs = 1'b1;
          next_r.hs_cnt = 12'h000;
          if (r.burst_cnt != 2'h0) begin
            next_r.burst_cnt = r.burst_cnt - 2'h1;
          end
        end
      end
    end else if (r.state != bgss_pkg::BGSS_BOOT) begin
      next_r.hs = 1'b0;
      next_r.ls = 1'b0;
      next_r.ls_hold = 1'b0;
      next_r.watch = 12'h000;
      next_r.force_cnt = 12'h000;
      next_r.off_cnt = 12'h000;
      next_r.burst_cnt = 2'h0;
    end
    if (next_r.hs) begin
      next_r.ls = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.state <= bgss_pkg::BGSS_OFF;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign high_side_gate = r.hs;
  assign low_side_gate = r.ls;
  assign softstart_enable = (r.state == bgss_pkg::BGSS_RUN);
  assign low_iq_mode = r.pskip;
  assign pin_low_seen = r.pin_low;
  assign reset_out_open_drain_out = 1'b0;
  assign reset_out_open_drain_oe_n = !((r.state != bgss_pkg::BGSS_OFF) && pull_low);
  assign discharge_1ma_en = r.ov && (r.state != bgss_pkg::BGSS_OFF);
  assign shutdown_pulldown_en = (r.state == bgss_pkg::BGSS_OFF) && vin_above_4v5;

  always_comb begin
    if (!softstart_enable || !softstart_done) begin
      error_amplifier_clamp = bgss_pkg::BGSS_CLAMP_NONE;
    end else if (r.burst_cnt != 2'h0) begin
      error_amplifier_clamp = bgss_pkg::BGSS_CLAMP_BURST;
    end else if (r.pskip) begin
      error_amplifier_clamp = bgss_pkg::BGSS_CLAMP_PSKIP;
    end else begin
      error_amplifier_clamp = bgss_pkg::BGSS_CLAMP_NORMAL;
    end
  end

endmodule
`default_nettype wire

// File: sim/bgss_props.sv
`timescale 1ns/1ps
`default_nettype none
module bgss_props #(
  parameter logic [25:0] RESET_PRODUCT = bgss_pkg::RESET_PRODUCT
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic current_limit,
  input wire logic undervoltage_threshold,
  input wire logic overvoltage_threshold,
  input wire logic output_below_regulation,
  input wire logic vin_above_4v5,
  input wire logic softstart_done,
  input wire logic reset_out_open_drain_oe_n,
  input wire logic high_side_gate,
  input wire logic low_side_gate,
  input wire logic softstart_enable,
  input wire logic discharge_1ma_en,
  input wire logic shutdown_pulldown_en,
  input wire logic low_iq_mode,
  input wire logic [1:0] error_amplifier_clamp
);
  // ------
  // Helper
  // ------
  // A counter bounds the long pulse, since a repetition of 160 would be too slow.
  localparam int HS_MAX = 160;
  logic [7:0] hs_len;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hs_len <= 8'h00;
    end else begin
      hs_len <= high_side_gate ? 8'(hs_len + 8'h01) : 8'h00;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence fault_run;
    (softstart_enable && (undervoltage_threshold || overvoltage_threshold))[*7];
  endsequence
  sequence ov_run;
    (overvoltage_threshold && softstart_enable)[*2];
  endsequence
  // ----------
  // Properties
  // ----------
  gates_exclusive_a: assert property (!(high_side_gate && low_side_gate))
    else $error("both gates on");
  reset_floats_off_a: assert property (shutdown_pulldown_en |-> reset_out_open_drain_oe_n)
    else $error("reset pin driven in shutdown");
  pulldown_rule_a: assert property (shutdown_pulldown_en |-> vin_above_4v5 && !high_side_gate && !low_side_gate)
    else $error("shutdown pull-down wrong");
  fault_pulls_low_a: assert property (fault_run ##1 fault_run |-> !reset_out_open_drain_oe_n)
    else $error("reset pin not pulled low");
  ov_discharge_a: assert property (ov_run |-> discharge_1ma_en)
    else $error("discharge path late");
  climit_ends_high_a: assert property (high_side_gate && current_limit |=> !high_side_gate)
    else $error("high pulse not cut");
  climit_skips_high_a: assert property (!high_side_gate && current_limit |=> !high_side_gate)
    else $error("high pulse not skipped");
  startup_clamp_a: assert property (!softstart_enable |-> error_amplifier_clamp == 2'h0)
    else $error("clamp set at startup");
  pskip_clamp_a: assert property (low_iq_mode && softstart_enable && softstart_done |-> error_amplifier_clamp == 2'h1)
    else $error("pulse-skip clamp wrong");
  pskip_demand_a: assert property ($rose(high_side_gate) && low_iq_mode && $past(low_iq_mode) |-> $past(output_below_regulation))
    else $error("burst without demand");
  high_width_a: assert property (hs_len <= HS_MAX)
    else $error("high pulse too long");
  fall_low_on_a: assert property ($fell(high_side_gate) && softstart_enable |=> low_side_gate)
    else $error("low gate not set");
endmodule
`default_nettype wire

// File: sim/bgss_power_model.sv
`timescale 1ns/1ps
`default_nettype none
module bgss_power_model (
  input wire logic mclk,
  input wire logic slow_node,
  input wire logic high_side_gate,
  input wire logic low_side_gate,
  input wire logic reset_out_open_drain_out,
  input wire logic reset_out_open_drain_oe_n,
  output logic switch_node_sense,
  output logic zero_current,
  output logic reset_wire
);
  // ------
  // Stage
  // ------
  // A slow node only falls once the low-side switch has pulled it down.
  logic [7:0] coil;
  initial begin
    coil = 8'h00;
    switch_node_sense = 1'b0;
  end
  always @(posedge mclk) begin
    switch_node_sense <= !high_side_gate && (!slow_node || low_side_gate);
    if (high_side_gate && coil != 8'hff) begin
      coil <= coil + 8'h01;
    end else if (low_side_gate && coil != 8'h00) begin
      coil <= coil - 8'h01;
    end
  end
  assign zero_current = (coil == 8'h00);
  // The pin has a pull-up, so a released pin reads high.
  assign reset_wire = reset_out_open_drain_oe_n ? 1'b1 : reset_out_open_drain_out;
endmodule
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk, nrst, enable_in, current_limit, pwm_trip, zero_current, switch_node_sense;
  logic undervoltage_threshold, overvoltage_threshold, low_input_threshold, light_load;
  logic output_below_regulation, vin_above_4v5, vout_below_0v2, softstart_done;
  logic reset_wire, reset_out_open_drain_out, reset_out_open_drain_oe_n, pin_low_seen;
  logic high_side_gate, low_side_gate, softstart_enable, discharge_1ma_en;
  logic shutdown_pulldown_en, low_iq_mode, slow_node, hs_q, ls_q;
  logic [1:0] error_amplifier_clamp;
  logic [10:0] pullup_current_ua;
  int error_cnt, samples_checked, cyc, run, hs_at, ls_at, rel;
  int hs_n, ls_n, hs_up, ls_up, hs_gap, ls_gap, hs_max;
  // ------
  // Parts
  // ------
  // A small release product keeps the reset delay short in simulation.
  bgss_top #(.RESET_PRODUCT(26'h00007d0)) dut_u (.mclk(mclk), .nrst(nrst),
    .enable_in(enable_in), .current_limit(current_limit), .pwm_trip(pwm_trip),
    .zero_current(zero_current), .switch_node_sense(switch_node_sense),
    .undervoltage_threshold(undervoltage_threshold),
    .overvoltage_threshold(overvoltage_threshold), .low_input_threshold(low_input_threshold),
    .output_below_regulation(output_below_regulation), .vin_above_4v5(vin_above_4v5),
    .vout_below_0v2(vout_below_0v2), .light_load(light_load),
    .softstart_done(softstart_done), .pullup_current_ua(pullup_current_ua),
    .reset_out_open_drain_in(reset_wire), .reset_out_open_drain_out(reset_out_open_drain_out),
    .reset_out_open_drain_oe_n(reset_out_open_drain_oe_n), .high_side_gate(high_side_gate),
    .low_side_gate(low_side_gate), .softstart_enable(softstart_enable),
    .discharge_1ma_en(discharge_1ma_en), .shutdown_pulldown_en(shutdown_pulldown_en),
    .low_iq_mode(low_iq_mode), .error_amplifier_clamp(error_amplifier_clamp),
    .pin_low_seen(pin_low_seen));
  bgss_power_model model_u (.mclk(mclk), .slow_node(slow_node),
    .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
    .reset_out_open_drain_out(reset_out_open_drain_out),
    .reset_out_open_drain_oe_n(reset_out_open_drain_oe_n),
    .switch_node_sense(switch_node_sense), .zero_current(zero_current),
    .reset_wire(reset_wire));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // ------
  // Tasks
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Counts gate activity at falling edges, where all outputs have settled.
  task automatic watch(input int n, input bit until_ss);
    hs_n = 0;
    ls_n = 0;
    hs_up = 0;
    ls_up = 0;
    hs_max = 0;
    repeat (n) begin
      @(negedge mclk);
      if (until_ss && softstart_enable === 1'b1) break;
      cyc++;
      hs_n += high_side_gate;
      ls_n += low_side_gate;
      run = high_side_gate ? run + 1 : 0;
      if (run > hs_max) hs_max = run;
      if (high_side_gate && !hs_q) begin
        hs_up++;
        hs_gap = cyc - hs_at;
        hs_at = cyc;
      end
      if (low_side_gate && !ls_q) begin
        ls_up++;
        ls_gap = cyc - ls_at;
        ls_at = cyc;
      end
      hs_q = high_side_gate;
      ls_q = low_side_gate;
    end
  endtask
  task automatic start_up(input logic skip);
    @(posedge mclk);
    vout_below_0v2 <= skip;
    softstart_done <= 1'b0;
    enable_in <= 1'b1;
    watch(1005, 1'b0);
    check(hs_n + ls_n, 0);
    check(error_amplifier_clamp, 2'h0);
    watch(400, 1'b1);
    check(softstart_enable, 1'b1);
    check(hs_n, 0);
    check(ls_up, skip ? 0 : 8);
    if (!skip) check(ls_n + ls_gap * 100, 24 + 2000);
    @(posedge mclk);
    softstart_done <= 1'b1;
    $display("test start_up done");
  endtask
  task automatic glitch_modes;
    @(posedge mclk);
    enable_in <= 1'b0;
    repeat (8) @(posedge mclk);
    enable_in <= 1'b1;
    watch(100, 1'b0);
    check(softstart_enable, 1'b1);
    check(error_amplifier_clamp, 2'h3);
    light_load <= 1'b1;
    watch(10, 1'b0);
    watch(40, 1'b0);
    check(low_iq_mode, 1'b1);
    check(error_amplifier_clamp, 2'h1);
    check(hs_n, 0);
    output_below_regulation <= 1'b1;
    watch(30, 1'b0);
    check(hs_up > 0, 1'b1);
    output_below_regulation <= 1'b0;
    light_load <= 1'b0;
    watch(10, 1'b0);
    check(error_amplifier_clamp, 2'h2);
    $display("test glitch_modes done");
  endtask
  task automatic limits;
    watch(100, 1'b0);
    current_limit <= 1'b1;
    watch(40, 1'b0);
    check(hs_n, 0);
    check(ls_n > 0, 1'b1);
    current_limit <= 1'b0;
    for (int i = 0; i < 20 && high_side_gate !== 1'b1; i++) @(negedge mclk);
    @(posedge mclk);
    current_limit <= 1'b1;
    repeat (2) @(negedge mclk);
    check(high_side_gate, 1'b0);
    current_limit <= 1'b0;
    low_input_threshold <= 1'b1;
    output_below_regulation <= 1'b1;
    slow_node <= 1'b1;
    watch(400, 1'b0);
    check(hs_max, 160);
    check(hs_gap, 162);
    low_input_threshold <= 1'b0;
    output_below_regulation <= 1'b0;
    slow_node <= 1'b0;
    $display("test limits done");
  endtask
  task automatic release_time;
    rel = 0;
    while (reset_out_open_drain_oe_n !== 1'b1 && rel < 200) begin
      @(negedge mclk);
      rel++;
    end
  endtask
  task automatic reset_pin;
    watch(20, 1'b0);
    check(reset_out_open_drain_oe_n, 1'b1);
    undervoltage_threshold <= 1'b1;
    watch(15, 1'b0);
    check(reset_out_open_drain_oe_n, 1'b0);
    check(pin_low_seen, 1'b1);
    undervoltage_threshold <= 1'b0;
    release_time();
    check(rel >= 10 && rel <= 13, 1'b1);
    pullup_current_ua <= 11'h064;
    overvoltage_threshold <= 1'b1;
    watch(15, 1'b0);
    check(discharge_1ma_en, 1'b1);
    check(reset_out_open_drain_oe_n, 1'b0);
    overvoltage_threshold <= 1'b0;
    release_time();
    check(rel >= 29 && rel <= 34, 1'b1);
    pullup_current_ua <= 11'h3e8;
    $display("test reset_pin done");
  endtask
  task automatic shut_down;
    @(posedge mclk);
    enable_in <= 1'b0;
    watch(140, 1'b0);
    check(hs_up > 10, 1'b1);
    watch(40, 1'b0);
    undervoltage_threshold <= 1'b1;
    watch(50, 1'b0);
    check(hs_n + ls_n, 0);
    check(shutdown_pulldown_en, 1'b1);
    check(reset_out_open_drain_oe_n, 1'b1);
    check(softstart_enable, 1'b0);
    undervoltage_threshold <= 1'b0;
    vin_above_4v5 <= 1'b0;
    @(negedge mclk);
    check(shutdown_pulldown_en, 1'b0);
    vin_above_4v5 <= 1'b1;
    $display("test shut_down done");
  endtask
  // ------
  // Run
  // ------
  initial begin
    {nrst, enable_in, current_limit, pwm_trip, undervoltage_threshold} = 5'h00;
    {overvoltage_threshold, low_input_threshold, output_below_regulation} = 3'h0;
    {vout_below_0v2, light_load, softstart_done, slow_node, hs_q, ls_q} = 6'h00;
    vin_above_4v5 = 1'b1;
    pullup_current_ua = 11'h3e8;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    start_up(1'b0);
    glitch_modes();
    limits();
    reset_pin();
    shut_down();
    start_up(1'b1);
    stop_test();
  end
  // The whole sequence needs about 3300 cycles.
  initial begin
    repeat (12000) @(posedge mclk);
    error_cnt++;
    stop_test();
  end
endmodule
bind bgss_top bgss_props #(.RESET_PRODUCT(RESET_PRODUCT)) props_u (.mclk(mclk),
  .nrst(nrst), .current_limit(current_limit), .undervoltage_threshold(undervoltage_threshold),
  .overvoltage_threshold(overvoltage_threshold), .softstart_done(softstart_done),
  .output_below_regulation(output_below_regulation), .vin_above_4v5(vin_above_4v5),
  .reset_out_open_drain_oe_n(reset_out_open_drain_oe_n), .high_side_gate(high_side_gate),
  .low_side_gate(low_side_gate), .softstart_enable(softstart_enable),
  .discharge_1ma_en(discharge_1ma_en), .shutdown_pulldown_en(shutdown_pulldown_en),
  .low_iq_mode(low_iq_mode), .error_amplifier_clamp(error_amplifier_clamp));
`default_nettype wire
